//--- verilog/tmmc_pkg.sv
// Constants shared by the transponder memory and mode control block.
// Assumes a single system clock; the field clock is sampled as a plain input.
package tmmc_pkg;
  // Array shape
  localparam int PAGES = 8;
  localparam int PAGE_W = 32;
  localparam logic [2:0] PG_SERIAL = 3'h0;
  localparam logic [2:0] PG_KEY_LO = 3'h1;
  localparam logic [2:0] PG_KEY_HI = 3'h2;
  localparam logic [2:0] PG_CFG = 3'h3;
  localparam logic [2:0] PG_USER_FIRST = 3'h4;
  localparam logic [2:0] PG_LEGACY_LAST = 3'h5;
  localparam logic [2:0] PG_USER_LAST = 3'h7;
  // Configuration byte sits in the top byte of page 3
  localparam int CFG_MSB = 31;
  localparam int CFG_LSB = 24;
  localparam int KEY_HI_MSB = 31;
  localparam int KEY_HI_LSB = 16;
  // Configuration byte fields
  localparam int CFG_CODING = 0;
  localparam int CFG_VER_LO = 1;
  localparam int CFG_VER_HI = 2;
  localparam int CFG_SECURE = 3;
  localparam int CFG_LOCK67 = 4;
  localparam int CFG_LOCK45 = 5;
  localparam int CFG_LOCK3 = 6;
  localparam int CFG_LOCK12 = 7;
  // Version field codes
  localparam logic [1:0] VER_ANIMAL = 2'h0;
  localparam logic [1:0] VER_LEGACY = 2'h1;
  localparam logic [1:0] VER_EMUL = 2'h2;
  localparam logic [1:0] VER_FULL = 2'h3;
  // Standard configuration byte values
  localparam logic [7:0] CFG_STD_PLAIN = 8'h06;
  localparam logic [7:0] CFG_STD_SECURE = 8'h0E;
  localparam logic [7:0] CFG_STD_LEGACY = 8'h02;
  localparam logic [7:0] CFG_STD_ANIMAL = 8'h00;
  localparam logic [7:0] CFG_STD_EMUL = 8'h04;
  // Commands from the framing layer
  localparam logic [2:0] CMD_START = 3'h0;
  localparam logic [2:0] CMD_AUTH = 3'h1;
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_HALT = 3'h4;
  // Timing: field clock edges for the waiting interval, and one more than the edges per broadcast word
  localparam int SYS_CLK_HZ = 25000000;
  localparam int LINK_PERIOD_NS = 320;
  localparam int WAIT_EDGES = 64;
  localparam int WORD_EDGES = 32;
  localparam int CNT_W = 16;
  // Top-level flow states
  typedef enum logic [5:0] {
    ST_LOAD = 6'h01,
    ST_WAIT = 6'h02,
    ST_AUTH = 6'h04,
    ST_OPEN = 6'h08,
    ST_HALT = 6'h10,
    ST_CAST = 6'h20
  } flow_state_t;
endpackage

//--- verilog/word_buffer.sv
// Two-entry word buffer with valid/ready on both sides.
// Assumes DEPTH is a power of two; synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module word_buffer #(
  parameter int W = 33,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } buf_state_t;

  buf_state_t buf_reg;
  buf_state_t buf_next;
  logic push;
  logic pop;

  // Honest flags straight from the count
  assign in_ready_o = (buf_reg.cnt != FULL_CNT);
  assign out_valid_o = (buf_reg.cnt != '0);
  assign out_data_o = buf_reg.mem[buf_reg.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer and count update; full refuses, so no word is lost on a stall
  always_comb begin
    buf_next = buf_reg;
    if (push) begin
      buf_next.mem[buf_reg.wp] = in_data_i;
      buf_next.wp = buf_reg.wp + 1'b1;
    end
    if (pop) begin
      buf_next.rp = buf_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      buf_next.cnt = buf_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      buf_next.cnt = buf_reg.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      buf_reg <= '0;
    end else begin
      buf_reg <= buf_next;
    end
  end
endmodule
`default_nettype wire

//--- verilog/transponder_memory_mode_control.sv
// Memory array, configuration decode, access rights and mode flow of the transponder.
// Assumes command framing, cipher and modulator live outside; the field clock
// arrives asynchronous and is sampled here; reset stands for power-up.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// RQ1: Eight 32-bit pages, 256 bits, pages 0-7.
// RQ2: Secure mode: serial, key low, key high, config.
// RQ3: Plain mode: page 1 holds reader secret.
// RQ4: Configuration byte fetched from array at power-up.
// RQ5: Config in page 3; bit0 coding, bit3 secure.
// RQ6: Bits 2:1 pick broadcast variant or full.
// RQ7: Legacy broadcast repeats pages 4 and 5.
// RQ8: Animal-ID broadcast repeats pages 4 to 7.
// RQ9: Emulation broadcast repeats pages 4 to 7.
// RQ10: After field entry wait for start command.
// RQ11: Authenticate before any page read or write.
// RQ12: Plain mode unencrypted, secure mode encrypted.
// RQ13: Plain mode checks reader secret before access.
// RQ14: Halt on request, then stay silent.
// RQ15: Broadcast starts after waiting interval expires.
// RQ16: Start during waiting interval leads to authentication.
// RQ17: Bit 4 set locks pages 6 and 7.
// RQ18: Bit 5 set locks pages 4 and 5.
// RQ19: Bit 6 locks page 3, never clears.
// RQ20: Bit 7 blocks writes pages 1-2, permanent.
// RQ21: Bit 7 hides page 1; page 2 per mode.
// RQ22: Reader writes final pages before setting locks.
// RQ23: Standard config values decode to their modes.
// RQ24: Key high and low form 48-bit key.
// RQ25: Reader secret compared for identity with page 1.
// RQ26: Write to locked page leaves contents unchanged.
module transponder_memory_mode_control
  import tmmc_pkg::*;
#(
  parameter int WAIT_LINK_EDGES = tmmc_pkg::WAIT_EDGES,
  parameter int WORD_LINK_EDGES = tmmc_pkg::WORD_EDGES,
  parameter logic [tmmc_pkg::PAGES-1:0][tmmc_pkg::PAGE_W-1:0] INIT_IMAGE = {
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0600_0000, 32'h0000_0000, 32'h0000_0000, 32'h1234_5678
  }
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Field clock from the analog front end
  input wire logic field_clk_i,
  // Command from the framing layer
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_code_i,
  input wire logic [2:0] cmd_page_i,
  input wire logic [tmmc_pkg::PAGE_W-1:0] cmd_data_i,
  input wire logic cipher_ok_i,
  output logic cmd_ready_o,
  // Answers and broadcast words toward the modulator
  output logic resp_valid_o,
  output logic [tmmc_pkg::PAGE_W-1:0] resp_data_o,
  output logic resp_err_o,
  input wire logic resp_ready_i,
  // Mode and status
  output logic [7:0] mode_and_lock_byte_o,
  output logic coding_biphase_o,
  output logic encrypt_o,
  output logic authorized_o,
  output logic silent_o,
  output logic broadcasting_o,
  output logic [47:0] key_o
);
  import tmmc_pkg::*;

  localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(WAIT_LINK_EDGES - 1);
  localparam logic [CNT_W-1:0] WORD_LAST = CNT_W'(WORD_LINK_EDGES - 1);

  typedef struct packed {
    flow_state_t state;
    logic [PAGES-1:0][PAGE_W-1:0] mem;
    logic [7:0] cfg;
    logic biphase;
    logic [2:0] sync;
    logic [CNT_W-1:0] cnt;
    logic [2:0] bpage;
  } ctl_state_t;

  ctl_state_t ctl_reg;
  ctl_state_t ctl_next;
  logic push_valid;
  logic [PAGE_W:0] push_data;
  logic push_ready;
  logic link_edge;
  logic is_secure;
  logic is_cast_cfg;
  logic [1:0] version;
  logic rd_ok;
  logic wr_ok;
  logic auth_ok;
  logic [2:0] cast_last;
  logic [PAGE_W-1:0] wr_word;

  // Rising field-clock edge seen only behind the second sampling stage
  assign link_edge = ctl_reg.sync[1] && !ctl_reg.sync[2];

  // Configuration decode from the latched byte
  assign is_secure = ctl_reg.cfg[CFG_SECURE]; // RQ5
  assign version = ctl_reg.cfg[CFG_VER_HI:CFG_VER_LO]; // RQ6
  assign is_cast_cfg = (version != VER_FULL); // RQ23
  assign cast_last = (version == VER_LEGACY) ? PG_LEGACY_LAST : PG_USER_LAST; // RQ7 RQ8 RQ9

  // Read rights per page
  always_comb begin
    rd_ok = 1'b1;
    if (ctl_reg.cfg[CFG_LOCK12] && cmd_page_i == PG_KEY_LO) begin
      rd_ok = 1'b0; // RQ21
    end
    if (ctl_reg.cfg[CFG_LOCK12] && cmd_page_i == PG_KEY_HI && is_secure) begin
      rd_ok = 1'b0; // RQ21
    end
  end

  // Write rights per page; serial page never writable
  always_comb begin
    unique case (cmd_page_i)
      PG_SERIAL: wr_ok = 1'b0;
      3'h1, 3'h2: wr_ok = !ctl_reg.cfg[CFG_LOCK12]; // RQ20
      PG_CFG: wr_ok = !ctl_reg.cfg[CFG_LOCK3]; // RQ19
      3'h4, 3'h5: wr_ok = !ctl_reg.cfg[CFG_LOCK45]; // RQ18
      3'h6, 3'h7: wr_ok = !ctl_reg.cfg[CFG_LOCK67]; // RQ17
    endcase
  end

  // One-time lock bits in page 3 survive any later write
  always_comb begin
    wr_word = cmd_data_i;
    if (cmd_page_i == PG_CFG) begin
      wr_word[CFG_LSB + CFG_LOCK3] = cmd_data_i[CFG_LSB + CFG_LOCK3] | ctl_reg.cfg[CFG_LOCK3]; // RQ19
      wr_word[CFG_LSB + CFG_LOCK12] =
        cmd_data_i[CFG_LSB + CFG_LOCK12] | ctl_reg.cfg[CFG_LOCK12]; // RQ20
    end
  end

  // Plain mode: identity against page 1; secure mode: cipher verdict
  assign auth_ok = is_secure ? cipher_ok_i : (cmd_data_i == ctl_reg.mem[PG_KEY_LO]); // RQ13 RQ25

  // Flow, access and broadcast pacing
  always_comb begin
    ctl_next = ctl_reg;
    ctl_next.sync = {ctl_reg.sync[1:0], field_clk_i};
    push_valid = 1'b0;
    push_data = '0;
    cmd_ready_o = 1'b0;
    unique case (ctl_reg.state)
      ST_LOAD: begin
        // Power-up fetch; coding fixed by variant except in full operation
        ctl_next.cfg = ctl_reg.mem[PG_CFG][CFG_MSB:CFG_LSB]; // RQ4 RQ5
        unique case (ctl_reg.mem[PG_CFG][CFG_LSB + CFG_VER_HI:CFG_LSB + CFG_VER_LO])
          VER_ANIMAL: ctl_next.biphase = 1'b1; // RQ6
          VER_LEGACY: ctl_next.biphase = 1'b0; // RQ6
          VER_EMUL: ctl_next.biphase = 1'b1; // RQ6
          VER_FULL: ctl_next.biphase = ctl_reg.mem[PG_CFG][CFG_LSB + CFG_CODING]; // RQ5
        endcase
        ctl_next.cnt = '0;
        ctl_next.state = ST_WAIT;
      end
      ST_WAIT: begin
        // Only the start command is heard here; others are swallowed
        cmd_ready_o = 1'b1;
        if (cmd_valid_i && cmd_code_i == CMD_START) begin
          ctl_next.state = ST_AUTH; // RQ10 RQ16
        end else if (is_cast_cfg && link_edge) begin
          ctl_next.cnt = ctl_reg.cnt + 1'b1;
          if (ctl_reg.cnt == WAIT_LAST) begin
            ctl_next.state = ST_CAST; // RQ15
            ctl_next.cnt = '0;
            ctl_next.bpage = PG_USER_FIRST;
          end
        end
      end
      ST_AUTH: begin
        // Answer needs buffer room, so hold the command while full
        cmd_ready_o = push_ready;
        if (cmd_valid_i && push_ready) begin
          if (cmd_code_i == CMD_AUTH) begin
            push_valid = 1'b1;
            push_data = {!auth_ok, {PAGE_W{1'b0}}};
            ctl_next.state = auth_ok ? ST_OPEN : ST_WAIT; // RQ11
          end else if (cmd_code_i == CMD_HALT) begin
            ctl_next.state = ST_HALT; // RQ14
          end else if (cmd_code_i != CMD_START) begin
            push_valid = 1'b1;
            push_data = {1'b1, {PAGE_W{1'b0}}}; // RQ11
          end
        end
      end
      ST_OPEN: begin
        cmd_ready_o = push_ready;
        if (cmd_valid_i && push_ready) begin
          unique case (cmd_code_i)
            CMD_READ: begin
              push_valid = 1'b1;
              push_data = {!rd_ok, rd_ok ? ctl_reg.mem[cmd_page_i] : {PAGE_W{1'b0}}}; // RQ21
            end
            CMD_WRITE: begin
              push_valid = 1'b1;
              push_data = {!wr_ok, {PAGE_W{1'b0}}};
              if (wr_ok) begin
                ctl_next.mem[cmd_page_i] = wr_word; // RQ26
                if (cmd_page_i == PG_CFG) begin
                  ctl_next.cfg[CFG_LOCK3] = wr_word[CFG_LSB + CFG_LOCK3]; // RQ19
                  ctl_next.cfg[CFG_LOCK12] = wr_word[CFG_LSB + CFG_LOCK12]; // RQ20
                end
              end
            end
            CMD_HALT: ctl_next.state = ST_HALT; // RQ14
            default: ctl_next.state = ctl_reg.state;
          endcase
        end
      end
      ST_HALT: begin
        // Muted until the field drops; commands drained without answer
        cmd_ready_o = 1'b1; // RQ14
      end
      ST_CAST: begin
        // Read-only cycle of user pages; a full buffer holds the word back
        cmd_ready_o = 1'b1;
        if (ctl_reg.cnt == WORD_LAST) begin
          if (push_ready) begin
            push_valid = 1'b1;
            push_data = {1'b0, ctl_reg.mem[ctl_reg.bpage]}; // RQ7 RQ8 RQ9
            ctl_next.cnt = '0;
            ctl_next.bpage = (ctl_reg.bpage == cast_last) ? PG_USER_FIRST :
              ctl_reg.bpage + 1'b1;
          end
        end else if (link_edge) begin
          ctl_next.cnt = ctl_reg.cnt + 1'b1;
        end
      end
    endcase
  end

  // Reset is power-up: array reloads its image, flow restarts at the fetch
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctl_reg.state <= ST_LOAD;
      ctl_reg.mem <= INIT_IMAGE; // RQ1
      ctl_reg.cfg <= CFG_STD_ANIMAL;
      ctl_reg.biphase <= 1'b0;
      ctl_reg.sync <= 3'h0;
      ctl_reg.cnt <= '0;
      ctl_reg.bpage <= PG_USER_FIRST;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // Output buffer so a stalled receiver loses no answer
  word_buffer #(
    .W(PAGE_W + 1),
    .DEPTH(2)
  ) u_out_buf (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(push_valid),
    .in_data_i(push_data),
    .in_ready_o(push_ready),
    .out_valid_o(resp_valid_o),
    .out_data_o({resp_err_o, resp_data_o}),
    .out_ready_i(resp_ready_i)
  );

  // Status straight from state flops
  assign mode_and_lock_byte_o = ctl_reg.cfg;
  assign coding_biphase_o = ctl_reg.biphase;
  assign authorized_o = (ctl_reg.state == ST_OPEN);
  assign encrypt_o = authorized_o && is_secure; // RQ12
  assign silent_o = (ctl_reg.state == ST_HALT);
  assign broadcasting_o = (ctl_reg.state == ST_CAST);
  assign key_o = {ctl_reg.mem[PG_KEY_HI][KEY_HI_MSB:KEY_HI_LSB], ctl_reg.mem[PG_KEY_LO]}; // RQ24 RQ2 RQ3
endmodule
`default_nettype wire

//--- tb/tmmc_chk.sv
// Port checker for the transponder memory and mode control block.
// Assumes one system clock domain; bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module tmmc_chk
  import tmmc_pkg::*;
(
  // Watched ports
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic [2:0] cmd_code_i,
  input wire logic resp_valid_o,
  input wire logic [PAGE_W-1:0] resp_data_o,
  input wire logic resp_err_o,
  input wire logic resp_ready_i,
  input wire logic [7:0] mode_and_lock_byte_o,
  input wire logic coding_biphase_o,
  input wire logic encrypt_o,
  input wire logic authorized_o,
  input wire logic silent_o,
  input wire logic broadcasting_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Config outputs settle one edge after release, hence the past guard
  a_coding_decode:
    assert property (!$past(sys_rst_i) |-> coding_biphase_o ==
      ((mode_and_lock_byte_o[2:1] == VER_FULL) ? mode_and_lock_byte_o[CFG_CODING] :
      (mode_and_lock_byte_o[2:1] != VER_LEGACY))) else $error("coding decode wrong");
  a_encrypt_mode:
    assert property (encrypt_o == (authorized_o && mode_and_lock_byte_o[CFG_SECURE]))
      else $error("encryption flag wrong");
  a_open_after_auth:
    assert property ($rose(authorized_o) |->
      $past(cmd_valid_i && cmd_ready_o && cmd_code_i == CMD_AUTH))
      else $error("opened without auth");
  a_cast_entry:
    assert property ($rose(broadcasting_o) |->
      mode_and_lock_byte_o[2:1] != VER_FULL && !$past(authorized_o))
      else $error("broadcast entered wrongly");
  a_cast_no_err:
    assert property (broadcasting_o && resp_valid_o |-> !resp_err_o)
      else $error("broadcast word flagged");
  a_halt_sticky:
    assert property (silent_o |=> silent_o) else $error("halt left");
  a_halt_quiet:
    assert property (silent_o && !resp_valid_o |=> !resp_valid_o)
      else $error("answer while halted");
  a_lock_sticky:
    assert property (!$past(sys_rst_i) |-> (mode_and_lock_byte_o[7:6] &
      $past(mode_and_lock_byte_o[7:6])) == $past(mode_and_lock_byte_o[7:6]))
      else $error("lock bit cleared");
  // Stalled word must not move or change
  a_resp_holds:
    assert property (resp_valid_o && !resp_ready_i |=> resp_valid_o &&
      $stable(resp_data_o) && $stable(resp_err_o)) else $error("stalled word lost");
endmodule
bind transponder_memory_mode_control tmmc_chk u_tmmc_chk (.sys_clk_i, .sys_rst_i,
  .cmd_valid_i, .cmd_ready_o, .cmd_code_i, .resp_valid_o, .resp_data_o, .resp_err_o,
  .resp_ready_i, .mode_and_lock_byte_o, .coding_biphase_o, .encrypt_o, .authorized_o,
  .silent_o, .broadcasting_o);
`default_nettype wire

//--- tb/field_reader_model.sv
// Reader side model: field clock plus a slow drain of the broadcast stream.
// Assumes the bench system clock; the field clock stands still with no field.
`timescale 1ns/1ps
`default_nettype none
module field_reader_model (
  // Clock and field control
  input wire logic sys_clk_i,
  input wire logic field_on_i,
  output logic field_clk_o,
  // Answer stream
  input wire logic resp_valid_i,
  input wire logic [31:0] resp_data_i,
  output logic resp_ready_o
);
  logic [31:0] words [$];
  // 320 ns field clock, held low while the field is off
  initial begin
    field_clk_o = 1'b0;
    forever #160 field_clk_o = field_on_i & ~field_clk_o;
  end
  // Ready on alternate cycles so the buffer sees stalls
  initial resp_ready_o = 1'b0;
  always @(negedge sys_clk_i) resp_ready_o <= ~resp_ready_o;
  // A word is taken where valid and ready meet
  always @(posedge sys_clk_i) begin
    if (resp_valid_i && resp_ready_o) begin
      words.push_back(resp_data_i);
    end
  end
endmodule
`default_nettype wire

//--- tb/transponder_memory_mode_control_tb.sv
// Bench: command flow on a plain-mode part, broadcast on a legacy-mode part.
// Assumes the design default image; short field counts keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module transponder_memory_mode_control_tb;
  import tmmc_pkg::*;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, field_on = 1'b1, field_clk, c_valid, c_ready;
  logic cmd_valid_i = 1'b0, cipher_ok_i = 1'b0, resp_ready_i = 1'b0, cmd_ready_o;
  logic [2:0] cmd_code_i = 3'h0, cmd_page_i = 3'h0;
  logic [31:0] cmd_data_i = 32'h0, resp_data_o, c_data;
  logic resp_valid_o, resp_err_o, coding_biphase_o, encrypt_o, authorized_o, silent_o;
  logic broadcasting_o, c_cast, c_code;
  // Broadcast part shares the command bus but never sees a valid command
  logic c_cmd_valid = 1'b0;
  logic [7:0] mode_and_lock_byte_o;
  logic [47:0] key_o;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  transponder_memory_mode_control #(.WAIT_LINK_EDGES(4), .WORD_LINK_EDGES(4))
  u_transponder_memory_mode_control (.sys_clk_i, .sys_rst_i, .field_clk_i(field_clk),
    .cmd_valid_i, .cmd_code_i, .cmd_page_i, .cmd_data_i, .cipher_ok_i, .cmd_ready_o,
    .resp_valid_o, .resp_data_o, .resp_err_o, .resp_ready_i, .mode_and_lock_byte_o,
    .coding_biphase_o, .encrypt_o, .authorized_o, .silent_o, .broadcasting_o, .key_o);
  // Legacy broadcast part; no commands, so it must broadcast on its own
  transponder_memory_mode_control #(.WAIT_LINK_EDGES(4), .WORD_LINK_EDGES(4),
    .INIT_IMAGE({32'h0, 32'h0, 32'hA5, 32'hA4, 32'h0200_0000, 32'h0, 32'h0, 32'h1234_5678}))
  u_transponder_memory_mode_control_cast (.sys_clk_i, .sys_rst_i, .field_clk_i(field_clk),
    .cmd_valid_i(c_cmd_valid), .cmd_code_i, .cmd_page_i, .cmd_data_i,
    .cipher_ok_i, .cmd_ready_o(), .resp_valid_o(c_valid), .resp_data_o(c_data),
    .resp_err_o(), .resp_ready_i(c_ready), .mode_and_lock_byte_o(), .coding_biphase_o(c_code),
    .encrypt_o(), .authorized_o(), .silent_o(), .broadcasting_o(c_cast), .key_o());
  field_reader_model u_field_reader_model (.sys_clk_i, .field_on_i(field_on),
    .field_clk_o(field_clk), .resp_valid_i(c_valid), .resp_data_i(c_data),
    .resp_ready_o(c_ready));
  // 25 MHz clock
  initial begin
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held from a falling edge until a rising edge sees ready
  task automatic send(logic [2:0] code, logic [2:0] page, logic [31:0] data);
    @(negedge sys_clk_i);
    cmd_code_i = code;
    cmd_page_i = page;
    cmd_data_i = data;
    cmd_valid_i = 1'b1;
    while (cmd_ready_o !== 1'b1) @(negedge sys_clk_i);
    @(negedge sys_clk_i);
    cmd_valid_i = 1'b0;
  endtask
  task automatic get(string what, logic err, logic [31:0] exp, logic use_data);
    while (resp_valid_o !== 1'b1) @(negedge sys_clk_i);
    resp_ready_i = 1'b1;
    chk(what, err, resp_err_o);
    if (use_data) chk(what, exp, resp_data_o);
    @(negedge sys_clk_i);
    resp_ready_i = 1'b0;
  endtask
  task automatic op(string what, logic [2:0] code, logic [2:0] page, logic [31:0] data,
    logic err, logic [31:0] exp, logic use_data);
    send(code, page, data);
    get(what, err, exp, use_data);
  endtask
  task automatic none(string what);
    repeat (6) @(negedge sys_clk_i);
    chk(what, 1'b0, resp_valid_o);
  endtask
  task automatic t_reset;
    chk("cfg byte", CFG_STD_PLAIN, mode_and_lock_byte_o);
    chk("coding", 1'b0, coding_biphase_o);
    chk("legacy coding", 1'b0, c_code);
    chk("early cast", 1'b0, c_cast);
    chk("auth flag", 1'b0, authorized_o);
    $display("test reset done");
  endtask
  task automatic t_auth;
    send(CMD_READ, PG_USER_FIRST, 32'h0);
    none("answer in wait");
    send(CMD_START, 3'h0, 32'h0);
    op("read early", CMD_READ, PG_USER_FIRST, 32'h0, 1'b1, 32'h0, 1'b0);
    cipher_ok_i = 1'b1;
    op("bad secret", CMD_AUTH, 3'h0, 32'h1, 1'b1, 32'h0, 1'b0);
    cipher_ok_i = 1'b0;
    chk("still closed", 1'b0, authorized_o);
    send(CMD_START, 3'h0, 32'h0);
    op("good secret", CMD_AUTH, 3'h0, 32'h0, 1'b0, 32'h0, 1'b0);
    chk("open", 1'b1, authorized_o);
    chk("plain", 1'b0, encrypt_o);
    $display("test auth done");
  endtask
  task automatic t_pages;
    op("write user", CMD_WRITE, PG_USER_FIRST, 32'hCAFE_0004, 1'b0, 32'h0, 1'b0);
    op("user page", CMD_READ, PG_USER_FIRST, 32'h0, 1'b0, 32'hCAFE_0004, 1'b1);
    op("write serial", CMD_WRITE, PG_SERIAL, 32'h0, 1'b1, 32'h0, 1'b0);
    op("serial", CMD_READ, PG_SERIAL, 32'h0, 1'b0, 32'h1234_5678, 1'b1);
    op("key lo", CMD_WRITE, PG_KEY_LO, 32'h1111_2222, 1'b0, 32'h0, 1'b0);
    op("key hi", CMD_WRITE, PG_KEY_HI, 32'h3333_0000, 1'b0, 32'h0, 1'b0);
    chk("key", 48'h3333_1111_2222, key_o);
    $display("test pages done");
  endtask
  task automatic t_locks;
    op("lock keys", CMD_WRITE, PG_CFG, 32'h8600_0000, 1'b0, 32'h0, 1'b0);
    op("key write", CMD_WRITE, PG_KEY_LO, 32'h0, 1'b1, 32'h0, 1'b0);
    op("key lo read", CMD_READ, PG_KEY_LO, 32'h0, 1'b1, 32'h0, 1'b1);
    op("key hi read", CMD_READ, PG_KEY_HI, 32'h0, 1'b0, 32'h3333_0000, 1'b1);
    op("lock cfg", CMD_WRITE, PG_CFG, 32'h4600_0000, 1'b0, 32'h0, 1'b0);
    op("cfg write", CMD_WRITE, PG_CFG, 32'h0, 1'b1, 32'h0, 1'b0);
    op("cfg read", CMD_READ, PG_CFG, 32'h0, 1'b0, 32'hC600_0000, 1'b1);
    chk("lock bits", 2'h3, mode_and_lock_byte_o[7:6]);
    chk("key kept", 48'h3333_1111_2222, key_o);
    $display("test locks done");
  endtask
  // Two undrained answers fill the buffer; a third request is refused
  task automatic t_buffer;
    send(CMD_READ, PG_USER_FIRST, 32'h0);
    send(CMD_READ, PG_LEGACY_LAST, 32'h0);
    @(negedge sys_clk_i);
    cmd_valid_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk("ready when full", 1'b0, cmd_ready_o);
    cmd_valid_i = 1'b0;
    get("first kept", 1'b0, 32'hCAFE_0004, 1'b1);
    get("second kept", 1'b0, 32'h0, 1'b1);
    $display("test buffer done");
  endtask
  task automatic t_halt;
    send(CMD_HALT, 3'h0, 32'h0);
    none("halt answer");
    chk("silent", 1'b1, silent_o);
    send(CMD_READ, PG_USER_FIRST, 32'h0);
    none("answer in halt");
    $display("test halt done");
  endtask
  task automatic t_cast;
    while (u_field_reader_model.words.size() < 3) @(negedge sys_clk_i);
    chk("cast flag", 1'b1, c_cast);
    for (int i = 0; i < 3; i++) begin
      chk("legacy word", (i % 2) ? 32'hA5 : 32'hA4, u_field_reader_model.words[i]);
    end
    $display("test cast done");
  endtask
  initial begin
    repeat (20) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    t_reset();
    t_auth();
    t_pages();
    t_locks();
    t_buffer();
    t_halt();
    t_cast();
    final_report();
  end
endmodule
`default_nettype wire
